// ---- logic/rla_pkg.sv ----
// Constants and state layout for the receive lane alignment status block
package rla_pkg;

    // Lane count and register bus widths
    localparam int          NUM_LANES      = 4;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;

    // Register byte offsets
    localparam logic [7:0]  OFS_MF_LEN     = 8'h00;
    localparam logic [7:0]  OFS_BER_THR    = 8'h04;
    localparam logic [7:0]  OFS_ALIGN_STAT = 8'h08;
    localparam logic [7:0]  OFS_BER_STAT   = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0]  OFS_LANE_STAT  = 8'h18;

    // Field positions
    localparam int          POS_ALIGNED    = 12;
    localparam int          POS_HI_BER     = 1;
    localparam int          POS_ALIGN_ERR  = 0;
    localparam int          POS_ARMED      = 4;
    localparam int          IRQ_W          = 5;
    localparam int          IRQ_MISALIGN   = 0;
    localparam int          IRQ_ALIGN_ERR  = 1;
    localparam int          IRQ_BIP        = 2;
    localparam int          IRQ_MARKER     = 3;
    localparam int          IRQ_HI_BER     = 4;

    // Reset values and the metaframe length minimum
    localparam logic [15:0] MF_LEN_RST     = 16'h0010;
    localparam logic [15:0] MF_LEN_MIN     = 16'h0002;
    localparam logic [15:0] BER_THR_RST    = 16'h0010;
    localparam logic [4:0]  IRQ_MASK_RST   = 5'h00;

    // Error rate measuring window
    localparam int          CLK_NS         = 10;
    localparam int          BER_WIN_NS     = 125000;
    localparam int          BER_WIN_CYC    = BER_WIN_NS / CLK_NS;

    // Whole block state, registered as one word
    typedef struct packed {
        logic [3:0]        seen;
        logic              armed;
        logic [3:0]        pend;
        logic [3:0][15:0]  tmr;
        logic              misalign;
        logic              aligned;
        logic              lfault;
        logic              aligned_err;
        logic              was_aligned;
        logic [3:0]        bip;
        logic [3:0]        mwerr;
        logic              hi_ber;
        logic [15:0]       wcnt;
        logic [15:0]       ecnt;
        logic [15:0]       mf_len;
        logic [15:0]       ber_thr;
        logic [4:0]        irq_st;
        logic [4:0]        irq_msk;
        logic              irq;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } rla_state_s;

endpackage : rla_pkg

// ---- logic/rla_status.sv ----
// Receive lane alignment, parity and error rate status with APB registers
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module rla_status
    import rla_pkg::*;
#(
    parameter int BER_WIN = BER_WIN_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic                   pready,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pslverr,
    input  wire logic [3:0]        marker_ok_i,
    input  wire logic [3:0]        marker_word_bad_i,
    input  wire logic [3:0]        bip_bad_i,
    input  wire logic [3:0]        lane_deskewed_i,
    input  wire logic              deskew_err_i,
    input  wire logic              sync_hdr_bad_i,
    output logic                   misalign_pulse_o,
    output logic                   align_loss_o,
    output logic      [3:0]        bip_err_pulse_o,
    output logic                   all_aligned_o,
    output logic                   local_fault_o,
    output logic                   pkt_accept_en_o,
    output logic                   high_error_rate_level,
    output logic      [3:0]        marker_word_error_pulse,
    output logic                   irq_o
);

    rla_state_s s_r;
    rla_state_s s_nxt;

    // Metaframe length never below two so a pulse can never land in the error cycle
    function automatic logic [15:0] mf_eff(input logic [15:0] len);
        mf_eff = (len < MF_LEN_MIN) ? MF_LEN_MIN : len;
    endfunction : mf_eff

    // Register read mux
    function automatic logic [31:0] rd_mux(input rla_state_s s, input logic [7:0] a);
        rd_mux = 32'h0000_0000;
        if (a == OFS_MF_LEN) begin
            rd_mux[15:0] = s.mf_len;
        end else if (a == OFS_BER_THR) begin
            rd_mux[15:0] = s.ber_thr;
        end else if (a == OFS_ALIGN_STAT) begin
            rd_mux[POS_ALIGNED]   = s.aligned;
            rd_mux[POS_ALIGN_ERR] = s.aligned_err;
            rd_mux[POS_ARMED]     = s.armed;
        end else if (a == OFS_BER_STAT) begin
            rd_mux[POS_HI_BER] = s.hi_ber;
        end else if (a == OFS_IRQ_STAT) begin
            rd_mux[IRQ_W-1:0] = s.irq_st;
        end else if (a == OFS_IRQ_MASK) begin
            rd_mux[IRQ_W-1:0] = s.irq_msk;
        end else if (a == OFS_LANE_STAT) begin
            rd_mux[3:0] = s.seen;
            rd_mux[7:4] = s.pend;
        end
    endfunction : rd_mux

    // Address decode shared by read and write paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == OFS_MF_LEN) || (a == OFS_BER_THR) || (a == OFS_ALIGN_STAT) ||
                  (a == OFS_BER_STAT) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
                  (a == OFS_LANE_STAT);
    endfunction : addr_ok

    logic       wr_acc;
    logic       setup;
    logic [4:0] ev;
    logic       all_desk;

    // Whole next state
    always_comb begin
        s_nxt    = s_r;
        setup    = psel && !penable;
        wr_acc   = psel && penable && pwrite && s_r.pready && !s_r.pslverr;
        all_desk = &lane_deskewed_i;

        // Armed once every lane has shown a good marker; sticky until reset
        s_nxt.seen  = s_r.seen | marker_ok_i;
        s_nxt.armed = s_r.armed | (&s_r.seen);

        // Per-lane delay timers; a lane error restarts its own timer
        s_nxt.misalign = 1'b0;
        for (int i = 0; i < NUM_LANES; i++) begin
            if (s_r.pend[i] && s_r.tmr[i] == 16'h0001) begin
                s_nxt.misalign = 1'b1;
            end
            if (marker_word_bad_i[i] && s_r.armed) begin
                s_nxt.pend[i] = 1'b1;
                s_nxt.tmr[i]  = mf_eff(s_r.mf_len) - 16'h0001;
            end else if (s_r.pend[i]) begin
                s_nxt.tmr[i]  = s_r.tmr[i] - 16'h0001;
                s_nxt.pend[i] = (s_r.tmr[i] != 16'h0001);
            end
        end

        // Alignment levels
        s_nxt.aligned     = all_desk && !deskew_err_i;
        s_nxt.lfault      = !s_nxt.aligned;
        s_nxt.was_aligned = s_r.was_aligned | s_nxt.aligned;
        s_nxt.aligned_err = deskew_err_i || (s_r.was_aligned && !all_desk);

        // Pulses follow their source by one cycle
        s_nxt.bip   = bip_bad_i;
        s_nxt.mwerr = marker_word_bad_i;

        // Error rate: count bad sync headers over a fixed window
        if (s_r.wcnt == 16'(BER_WIN - 1)) begin
            s_nxt.wcnt   = 16'h0000;
            s_nxt.ecnt   = {15'h0000, sync_hdr_bad_i};
            s_nxt.hi_ber = (s_r.ecnt >= s_r.ber_thr);
        end else begin
            s_nxt.wcnt = s_r.wcnt + 16'h0001;
            if (sync_hdr_bad_i && s_r.ecnt != 16'hFFFF) begin
                s_nxt.ecnt = s_r.ecnt + 16'h0001;
            end
            if (s_r.ecnt >= s_r.ber_thr) begin
                s_nxt.hi_ber = 1'b1;
            end
        end

        // Events; a new event wins over a same-cycle clear
        ev[IRQ_MISALIGN]  = s_nxt.misalign;
        ev[IRQ_ALIGN_ERR] = s_nxt.aligned_err && !s_r.aligned_err;
        ev[IRQ_BIP]       = |bip_bad_i;
        ev[IRQ_MARKER]    = |marker_word_bad_i;
        ev[IRQ_HI_BER]    = s_nxt.hi_ber && !s_r.hi_ber;
        s_nxt.irq_st = s_r.irq_st | ev;
        if (wr_acc && paddr == OFS_IRQ_STAT) begin
            s_nxt.irq_st = (s_r.irq_st & ~pwdata[IRQ_W-1:0]) | ev;
        end
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_msk);

        // Register writes
        if (wr_acc && paddr == OFS_MF_LEN) begin
            s_nxt.mf_len = pwdata[15:0];
        end else if (wr_acc && paddr == OFS_BER_THR) begin
            s_nxt.ber_thr = pwdata[15:0];
        end else if (wr_acc && paddr == OFS_IRQ_MASK) begin
            s_nxt.irq_msk = pwdata[IRQ_W-1:0];
            s_nxt.irq     = |(s_nxt.irq_st & pwdata[IRQ_W-1:0]);
        end

        // APB answer: prepared in setup, shown for exactly the first access cycle
        s_nxt.pready  = setup;
        s_nxt.pslverr = setup && !addr_ok(paddr);
        s_nxt.prdata  = (setup && !pwrite) ? rd_mux(s_r, paddr) : 32'h0000_0000;
    end

    // State register; every status output resets to zero except local_fault_o, which resets to one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r         <= '0;
            s_r.mf_len  <= MF_LEN_RST;
            s_r.ber_thr <= BER_THR_RST;
            s_r.irq_msk <= IRQ_MASK_RST;
            s_r.lfault  <= 1'b1;                                         // Fault while not aligned
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign pready                  = s_r.pready;
    assign prdata                  = s_r.prdata;
    assign pslverr                 = s_r.pslverr;
    assign misalign_pulse_o        = s_r.misalign;
    assign align_loss_o            = s_r.aligned_err;
    assign bip_err_pulse_o         = s_r.bip;
    assign all_aligned_o           = s_r.aligned;
    assign local_fault_o           = s_r.lfault;
    assign pkt_accept_en_o         = s_r.aligned;
    assign high_error_rate_level   = s_r.hi_ber;
    assign marker_word_error_pulse = s_r.mwerr;
    assign irq_o                   = s_r.irq;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_unarmed_quiet;
        !s_r.armed |=> !misalign_pulse_o;
    endproperty
    a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("alignment error while unarmed");

    property p_mf_delay;
        (marker_word_bad_i[0] && s_r.armed && s_r.mf_len == MF_LEN_RST) |-> ##16 misalign_pulse_o;
    endproperty
    a_mf_delay: assert property (p_mf_delay) else $error("alignment error not one metaframe late");

    property p_misalign_cause;
        misalign_pulse_o |-> $past(|s_r.pend) && $past(s_r.armed);
    endproperty
    a_misalign_cause: assert property (p_misalign_cause) else $error("alignment error without cause");

    property p_bip;
        bip_bad_i[2] |=> bip_err_pulse_o[2] ##1 (bip_err_pulse_o[2] == $past(bip_bad_i[2]));
    endproperty
    a_bip: assert property (p_bip) else $error("lane parity pulse wrong");

    property p_mwerr;
        !marker_word_bad_i[1] |=> !marker_word_error_pulse[1];
    endproperty
    a_mwerr: assert property (p_mwerr) else $error("marker word pulse without error");

    property p_aligned;
        (!(&lane_deskewed_i) || deskew_err_i) |=> !all_aligned_o && local_fault_o && !pkt_accept_en_o;
    endproperty
    a_aligned: assert property (p_aligned) else $error("aligned while a lane is not");

    property p_loss;
        deskew_err_i |=> align_loss_o;
    endproperty
    a_loss: assert property (p_loss) else $error("alignment loss not raised");

    property p_hiber;
        (s_r.ecnt >= s_r.ber_thr) |=> high_error_rate_level;
    endproperty
    a_hiber: assert property (p_hiber) else $error("high error rate not raised");

    property p_mgmt_bit;
        (psel && !penable && !pwrite && paddr == OFS_ALIGN_STAT) |=> prdata[POS_ALIGNED] == $past(s_r.aligned);
    endproperty
    a_mgmt_bit: assert property (p_mgmt_bit) else $error("aligned bit misread");

endmodule : rla_status

// ---- verif/rla_mgmt_model.sv ----
// Management side model that counts status pulses from the aligner
`timescale 1ns/10ps
module rla_mgmt_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       misalign_pulse,
    input  wire logic [3:0] bip_pulse,
    output logic      [7:0] misalign_cnt,
    output logic      [7:0] bip_cnt
);
    // Counts every high cycle, so a stretched pulse shows up as extra counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misalign_cnt <= 8'h00;
            bip_cnt      <= 8'h00;
        end else begin
            misalign_cnt <= misalign_cnt + {7'h00, misalign_pulse};
            bip_cnt      <= bip_cnt + 8'($countones(bip_pulse));
        end
    end
endmodule : rla_mgmt_model

// ---- verif/tb_rx_lane_alignment_status.sv ----
// Self-checking bench for the receive lane alignment status block
`timescale 1ns/10ps
module tb_rx_lane_alignment_status;
    import rla_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0]        mk_ok, mk_bad, bip_bad, deskewed, bip_o, mw_o;
    logic              dsk_err, sh_bad, mis_o, loss_o, algn_o, lf_o, acc_o, hi_o, irq_o;
    logic [7:0]        mis_cnt, bip_cnt;
    int                miscompares, comparisons;

    // Short error-rate window keeps the run brief
    rla_status #(.BER_WIN(50)) rla_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .marker_ok_i(mk_ok), .marker_word_bad_i(mk_bad),
        .bip_bad_i(bip_bad), .lane_deskewed_i(deskewed), .deskew_err_i(dsk_err),
        .sync_hdr_bad_i(sh_bad), .misalign_pulse_o(mis_o), .align_loss_o(loss_o),
        .bip_err_pulse_o(bip_o), .all_aligned_o(algn_o), .local_fault_o(lf_o),
        .pkt_accept_en_o(acc_o), .high_error_rate_level(hi_o), .marker_word_error_pulse(mw_o),
        .irq_o(irq_o));
    rla_mgmt_model rla_mgmt_model_inst (.pclk(pclk), .presetn(presetn), .misalign_pulse(mis_o),
        .bip_pulse(bip_o), .misalign_cnt(mis_cnt), .bip_cnt(bip_cnt));

    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            print_verdict();
        end
        if (!wr) chk("prdata", exp, prdata);
        chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    endtask : apb

    task automatic t_reset();
        chk("local_fault", 1, lf_o);
        chk("outputs", 0, {mis_o, loss_o, algn_o, acc_o, hi_o, irq_o, bip_o, mw_o});
        apb(1'b0, OFS_MF_LEN, 0, 32'h10, 1'b0);
        apb(1'b0, OFS_BER_THR, 0, 32'h10, 1'b0);
        apb(1'b0, OFS_IRQ_MASK, 0, 0, 1'b0);
        apb(1'b0, 8'h1C, 0, 0, 1'b1);
    endtask : t_reset

    // Three lanes seen only: a bad marker must not raise misalignment
    task automatic t_prearm();
        @(posedge pclk);
        mk_ok  <= 4'h7;
        mk_bad <= 4'h4;
        @(posedge pclk);
        mk_ok  <= 4'h0;
        mk_bad <= 4'h0;
        #1 chk("marker_err", 4'h4, mw_o);
        repeat (20) begin
            @(posedge pclk);
            #1 chk("misalign", 0, mis_o);
        end
    endtask : t_prearm

    // Arm, then bad markers on two lanes in consecutive cycles
    task automatic t_misalign();
        apb(1'b1, OFS_MF_LEN, 32'h4, 0, 1'b0);
        apb(1'b0, OFS_MF_LEN, 0, 32'h4, 1'b0);
        mk_ok  <= 4'h8;
        @(posedge pclk);
        mk_ok  <= 4'h0;
        repeat (3) @(posedge pclk);
        mk_bad <= 4'h1;
        for (int k = 1; k <= 7; k++) begin
            @(posedge pclk);
            mk_bad <= (k == 1) ? 4'h2 : 4'h0;
            #1 chk("marker_err", (k == 1) ? 1 : (k == 2) ? 2 : 0, mw_o);
            chk("misalign", (k == 4 || k == 5), mis_o);
        end
        chk("misalign_cnt", 2, mis_cnt);
    endtask : t_misalign

    task automatic t_bip();
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            bip_bad <= 4'(1 << i);
            @(posedge pclk);
            bip_bad <= 4'h0;
            #1 chk("bip", 1 << i, bip_o);
            @(posedge pclk);
            #1 chk("bip", 0, bip_o);
        end
        chk("bip_cnt", 4, bip_cnt);
    endtask : t_bip

    task automatic t_irq();
        apb(1'b0, OFS_IRQ_STAT, 0, 32'h0D, 1'b0);
        chk("irq", 0, irq_o);
        apb(1'b1, OFS_IRQ_MASK, 32'h1, 0, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk("irq", 1, irq_o);
        apb(1'b1, OFS_IRQ_STAT, 32'h1F, 0, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk("irq", 0, irq_o);
        apb(1'b0, OFS_IRQ_STAT, 0, 0, 1'b0);
    endtask : t_irq

    task automatic t_align();
        @(posedge pclk);
        deskewed <= 4'hF;
        repeat (2) @(posedge pclk);
        #1 chk("aligned", 3'b110, {algn_o, acc_o, lf_o});
        chk("loss", 0, loss_o);
        apb(1'b0, OFS_ALIGN_STAT, 0, 32'h1010, 1'b0);
        deskewed <= 4'hB;
        repeat (2) @(posedge pclk);
        #1 chk("aligned", 3'b001, {algn_o, acc_o, lf_o});
        chk("loss", 1, loss_o);
        apb(1'b0, OFS_ALIGN_STAT, 0, 32'h0011, 1'b0);
        deskewed <= 4'hF;
        dsk_err  <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk("aligned", 3'b001, {algn_o, acc_o, lf_o});
        chk("loss", 1, loss_o);
    endtask : t_align

    // Five bad headers straddle at most one window edge, so one side holds three
    task automatic t_hiber();
        int n;
        apb(1'b1, OFS_BER_THR, 32'h3, 0, 1'b0);
        sh_bad <= 1'b1;
        repeat (5) @(posedge pclk);
        sh_bad <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk("hi_ber", 1, hi_o);
        apb(1'b0, OFS_BER_STAT, 0, 32'h2, 1'b0);
        n = 0;
        while (hi_o !== 1'b0 && n < 150) begin
            @(posedge pclk);
            #1 n++;
        end
        if (n >= 150) begin
            miscompares++;
            print_verdict();
        end
        apb(1'b0, OFS_IRQ_STAT, 0, 32'h12, 1'b0);
    endtask : t_hiber

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, dsk_err, sh_bad} = '0;
        {paddr, pwdata, mk_ok, mk_bad, bip_bad, deskewed} = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1 t_reset();
        t_prearm();
        t_misalign();
        t_bip();
        t_irq();
        t_align();
        t_hiber();
        print_verdict();
    end
endmodule : tb_rx_lane_alignment_status
